// ===== include/ufc_consts.vh
// Register offsets, field positions, reset values for the flow-control block.
`ifndef UFC_CONSTS_VH
`define UFC_CONSTS_VH
`define UFC_OFF_EFR 8'h00
`define UFC_OFF_RES1 8'h04
`define UFC_OFF_RES2 8'h08
`define UFC_OFF_PAU1 8'h0C
`define UFC_OFF_PAU2 8'h10
`define UFC_OFF_MCR 8'h14
`define UFC_OFF_IER 8'h18
`define UFC_OFF_ISR 8'h1C
`define UFC_OFF_MSR 8'h20
`define UFC_OFF_DLL 8'h24
`define UFC_OFF_DLM 8'h28
`define UFC_OFF_LVL 8'h2C
`define UFC_OFF_IST 8'h30
`define UFC_OFF_ICL 8'h34
`define UFC_OFF_IEN 8'h38
`define UFC_EFR_SPEC 5
`define UFC_EFR_ARTS 6
`define UFC_EFR_ACTS 7
`define UFC_MCR_DTR 0
`define UFC_MCR_RTS 1
`define UFC_MCR_OP2 3
`define UFC_IER_SPEC 5
`define UFC_ISR_SPEC 4
`define UFC_CMP_NONE 2'h0
`define UFC_CMP_SECOND 2'h1
`define UFC_CMP_FIRST 2'h2
`define UFC_CMP_BOTH 2'h3
`define UFC_EV_SPEC 0
`define UFC_EV_PAUSE 1
`define UFC_EV_RESUME 2
`define UFC_EV_TRIG 3
`define UFC_RST_BYTE 8'h00
`define UFC_RST_ISR 8'h01
`define UFC_RST_DLL 8'h01
`define UFC_RST_DLM 8'h00
`define UFC_RST_TRIG 6'h08
`define UFC_RST_UPPER 6'h10
`define UFC_RST_LOWER 6'h04
`define UFC_RESP_OKAY 2'h0
`define UFC_RESP_SLVERR 2'h2
`endif

// ===== src/ufc_channel.v
// Enhanced flow-control logic of one UART channel with an AXI4-Lite slave.
`timescale 1ns/1ns
`include "ufc_consts.vh"
module ufc_channel #(
    parameter CONT_IRQ = 1'b0
) (
    input wire clk_sys,
    input wire rst,
    input wire porRst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire rxCharValid,
    input wire [7:0] rxCharData,
    input wire [5:0] rxFifoLevel,
    output reg rxStoreValid,
    output reg [7:0] rxStoreData,
    output reg pauseSeen,
    output reg resumeSeen,
    input wire ctsN,
    input wire dsrN,
    input wire riN,
    input wire cdN,
    output reg txStartOk,
    output reg rtsN,
    output reg dtrN,
    input wire irqOutputSelect,
    output reg intOut,
    output reg intOe,
    output reg irq,
    output reg [15:0] baudDivisor
);
    reg [7:0] efr_q;
    reg [7:0] resume1_q;
    reg [7:0] resume2_q;
    reg [7:0] pause1_q;
    reg [7:0] pause2_q;
    reg [7:0] mcr_q;
    reg [7:0] ier_q;
    reg specStat_q;
    reg [3:0] msrDelta_q;
    reg [3:0] modemPrev_q;
    reg primed_q;
    reg [5:0] trigLvl_q;
    reg [5:0] upperLvl_q;
    reg [5:0] lowerLvl_q;
    reg [3:0] irqStat_q;
    reg [3:0] irqEn_q;
    reg [5:0] lvlPrev_q;
    reg throttle_q;
    reg [7:0] awAddr_q;
    reg awHave_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    reg wHave_q;
    reg [7:0] dll_q;
    reg [7:0] dlm_q;
    reg [31:0] rdVal;
    reg rdHit;
    reg wrHit;
    reg [3:0] ev;
    reg specMatch;
    reg pauseMatch;
    reg resumeMatch;
    reg dropChar;
    reg [3:0] deltaSet;
    wire [3:0] modemNow;
    wire doWrite;
    wire doRead;
    wire wrEn;
    wire [7:0] wByte;
    wire [1:0] cmpSel;

    // Compares a character against one or two programmed characters.
    function pairHit;
        input [7:0] c;
        input [7:0] a;
        input [7:0] b;
        input [1:0] sel;
        begin
            case (sel)
                `UFC_CMP_FIRST: pairHit = (c == a);
                `UFC_CMP_SECOND: pairHit = (c == b);
                `UFC_CMP_BOTH: pairHit = (c == a) || (c == b);
                default: pairHit = 1'b0;
            endcase
        end
    endfunction

    assign modemNow = {cdN, riN, dsrN, ctsN};
    assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
    assign doRead = s_axi_arvalid && s_axi_arready;
    assign wrEn = doWrite && wStrb_q[0];
    assign wByte = wData_q[7:0];
    assign cmpSel = efr_q[1:0];

    // Character classification of each received byte.
    always @* begin
        specMatch = efr_q[`UFC_EFR_SPEC] && (rxCharData == pause2_q);
        pauseMatch = pairHit(rxCharData, pause1_q, pause2_q, cmpSel);
        resumeMatch = pairHit(rxCharData, resume1_q, resume2_q, cmpSel);
        // In first-pair mode the special match is independent and stored.
        dropChar = pauseMatch || resumeMatch;
        if (specMatch && cmpSel == `UFC_CMP_FIRST) begin
            dropChar = 1'b0;
        end
        if (specMatch && cmpSel == `UFC_CMP_NONE) begin
            dropChar = 1'b0;
        end
    end

    // Event sources for the sticky interrupt status.
    always @* begin
        ev = 4'h0;
        ev[`UFC_EV_SPEC] = rxCharValid && specMatch && ier_q[`UFC_IER_SPEC];
        ev[`UFC_EV_PAUSE] = rxCharValid && pauseMatch;
        ev[`UFC_EV_RESUME] = rxCharValid && resumeMatch;
        ev[`UFC_EV_TRIG] = efr_q[`UFC_EFR_ARTS] && (rxFifoLevel >= trigLvl_q)
            && (lvlPrev_q < trigLvl_q);
        deltaSet = 4'h0;
        if (primed_q) begin
            deltaSet[0] = modemNow[0] ^ modemPrev_q[0];
            deltaSet[1] = modemNow[1] ^ modemPrev_q[1];
            deltaSet[2] = modemNow[2] && !modemPrev_q[2];
            deltaSet[3] = modemNow[3] ^ modemPrev_q[3];
        end
    end

    // Register read multiplexer.
    always @* begin
        rdVal = 32'h00000000;
        rdHit = 1'b1;
        case (s_axi_araddr)
            `UFC_OFF_EFR: rdVal[7:0] = efr_q;
            `UFC_OFF_RES1: rdVal[7:0] = resume1_q;
            `UFC_OFF_RES2: rdVal[7:0] = resume2_q;
            `UFC_OFF_PAU1: rdVal[7:0] = pause1_q;
            `UFC_OFF_PAU2: rdVal[7:0] = pause2_q;
            `UFC_OFF_MCR: rdVal[7:0] = mcr_q;
            `UFC_OFF_IER: rdVal[7:0] = ier_q;
            `UFC_OFF_ISR: rdVal[7:0] = {3'h0, specStat_q, 3'h0, ~irq};
            `UFC_OFF_MSR: rdVal[7:0] = {~modemNow, msrDelta_q};
            `UFC_OFF_DLL: rdVal[7:0] = dll_q;
            `UFC_OFF_DLM: rdVal[7:0] = dlm_q;
            `UFC_OFF_LVL: rdVal[21:0] = {lowerLvl_q, 2'h0, upperLvl_q,
                2'h0, trigLvl_q};
            `UFC_OFF_IST: rdVal[3:0] = irqStat_q;
            `UFC_OFF_ICL: rdVal = 32'h00000000;
            `UFC_OFF_IEN: rdVal[3:0] = irqEn_q;
            default: rdHit = 1'b0;
        endcase
    end

    // Write address decode.
    always @* begin
        case (awAddr_q)
            `UFC_OFF_EFR, `UFC_OFF_RES1, `UFC_OFF_RES2, `UFC_OFF_PAU1,
            `UFC_OFF_PAU2, `UFC_OFF_MCR, `UFC_OFF_IER, `UFC_OFF_DLL,
            `UFC_OFF_DLM, `UFC_OFF_LVL, `UFC_OFF_ICL,
            `UFC_OFF_IEN: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
    end

    // Divisor is set to 0x0001 only by the power-up reset.
    always @(posedge clk_sys or posedge porRst) begin
        if (porRst) begin
            dll_q <= `UFC_RST_DLL;
            dlm_q <= `UFC_RST_DLM;
            baudDivisor <= {`UFC_RST_DLM, `UFC_RST_DLL};
        end else begin
            if (wrEn && awAddr_q == `UFC_OFF_DLL) begin
                dll_q <= wByte;
            end
            if (wrEn && awAddr_q == `UFC_OFF_DLM) begin
                dlm_q <= wByte;
            end
            baudDivisor <= {dlm_q, dll_q};
        end
    end

    // Interrupt pin enable is the select input OR MCR OP2 OR CONT_IRQ, also during reset.
    always @(posedge clk_sys) begin
        intOe <= CONT_IRQ | irqOutputSelect | mcr_q[`UFC_MCR_OP2];
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UFC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `UFC_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            awAddr_q <= 8'h00;
            awHave_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            wHave_q <= 1'b0;
            efr_q <= `UFC_RST_BYTE;
            resume1_q <= `UFC_RST_BYTE;
            resume2_q <= `UFC_RST_BYTE;
            pause1_q <= `UFC_RST_BYTE;
            pause2_q <= `UFC_RST_BYTE;
            mcr_q <= `UFC_RST_BYTE;
            ier_q <= `UFC_RST_BYTE;
            specStat_q <= 1'b0;
            msrDelta_q <= 4'h0;
            modemPrev_q <= 4'hF;
            primed_q <= 1'b0;
            trigLvl_q <= `UFC_RST_TRIG;
            upperLvl_q <= `UFC_RST_UPPER;
            lowerLvl_q <= `UFC_RST_LOWER;
            irqStat_q <= 4'h0;
            irqEn_q <= 4'h0;
            lvlPrev_q <= 6'h00;
            throttle_q <= 1'b0;
            rxStoreValid <= 1'b0;
            rxStoreData <= 8'h00;
            pauseSeen <= 1'b0;
            resumeSeen <= 1'b0;
            txStartOk <= 1'b1;
            rtsN <= 1'b1;
            dtrN <= 1'b1;
            intOut <= 1'b0;
            irq <= 1'b0;
        end else begin
            // Address and data channels are accepted independently.
            s_axi_awready <= !awHave_q && !s_axi_awready && !doWrite
                && !s_axi_bvalid;
            s_axi_wready <= !wHave_q && !s_axi_wready && !doWrite
                && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_q <= s_axi_awaddr;
                awHave_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                wHave_q <= 1'b1;
            end
            if (doWrite) begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? `UFC_RESP_OKAY : `UFC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (doRead) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdVal;
                s_axi_rresp <= rdHit ? `UFC_RESP_OKAY : `UFC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (wrEn) begin
                case (awAddr_q)
                    `UFC_OFF_EFR: efr_q <= wByte;
                    `UFC_OFF_RES1: resume1_q <= wByte;
                    `UFC_OFF_RES2: resume2_q <= wByte;
                    `UFC_OFF_PAU1: pause1_q <= wByte;
                    `UFC_OFF_PAU2: pause2_q <= wByte;
                    `UFC_OFF_MCR: mcr_q <= wByte;
                    `UFC_OFF_IER: ier_q <= wByte;
                    `UFC_OFF_LVL: begin
                        trigLvl_q <= wData_q[5:0];
                        upperLvl_q <= wData_q[13:8];
                        lowerLvl_q <= wData_q[21:16];
                    end
                    `UFC_OFF_IEN: irqEn_q <= wData_q[3:0];
                    default: irqEn_q <= irqEn_q;
                endcase
            end
            // Sticky status: a new event wins over a clear.
            if (wrEn && awAddr_q == `UFC_OFF_ICL) begin
                irqStat_q <= (irqStat_q & ~wData_q[3:0]) | ev;
            end else begin
                irqStat_q <= irqStat_q | ev;
            end
            irq <= |(irqStat_q & irqEn_q);
            intOut <= |(irqStat_q & irqEn_q);
            if (rxCharValid && specMatch) begin
                specStat_q <= 1'b1;
            end else if (doRead && s_axi_araddr == `UFC_OFF_ISR) begin
                specStat_q <= 1'b0;
            end
            primed_q <= 1'b1;
            modemPrev_q <= modemNow;
            if (doRead && s_axi_araddr == `UFC_OFF_MSR) begin
                msrDelta_q <= deltaSet;
            end else begin
                msrDelta_q <= msrDelta_q | deltaSet;
            end
            // In second-pair mode a matched pause character is dropped.
            rxStoreValid <= rxCharValid && !dropChar;
            rxStoreData <= rxCharData;
            pauseSeen <= rxCharValid && pauseMatch;
            resumeSeen <= rxCharValid && resumeMatch;
            lvlPrev_q <= rxFifoLevel;
            if (!efr_q[`UFC_EFR_ARTS] || !mcr_q[`UFC_MCR_RTS]) begin
                throttle_q <= 1'b0;
            end else if (rxFifoLevel >= upperLvl_q) begin
                throttle_q <= 1'b1;
            end else if (rxFifoLevel < lowerLvl_q) begin
                throttle_q <= 1'b0;
            end
            if (efr_q[`UFC_EFR_ARTS] && mcr_q[`UFC_MCR_RTS]) begin
                rtsN <= throttle_q;
            end else begin
                rtsN <= !mcr_q[`UFC_MCR_RTS];
            end
            dtrN <= !mcr_q[`UFC_MCR_DTR];
            // The shifter samples this only at a character start.
            txStartOk <= !(efr_q[`UFC_EFR_ACTS] && ctsN);
        end
    end
endmodule

// ===== sim/ufc_channel_asserts.sv
// Checker of bus handshakes and line outputs of the flow-control block.
`timescale 1ns/1ns
module ufc_channel_asserts (
    input wire clk_sys,
    input wire rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire rxCharValid,
    input wire [7:0] rxCharData,
    input wire rxStoreValid,
    input wire [7:0] rxStoreData,
    input wire pauseSeen,
    input wire resumeSeen,
    input wire ctsN,
    input wire txStartOk,
    input wire irqOutputSelect,
    input wire intOe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_resp_due_a: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
        else $error("Write response missing.");
    rd_resp_due_a: assert property (rdTaken |=> s_axi_rvalid)
        else $error("Read response missing.");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response not held.");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("Address taken while response pending.");
    store_echo_a: assert property (rxStoreValid |-> $past(rxCharValid)
        && rxStoreData == $past(rxCharData))
        else $error("Stored character differs from received one.");
    match_cause_a: assert property (pauseSeen || resumeSeen
        |-> $past(rxCharValid))
        else $error("Match flag without received character.");
    cts_free_a: assert property (!ctsN |=> txStartOk)
        else $error("Transmitter paused with clear-to-send low.");
    int_enable_a: assert property ($past(irqOutputSelect) |-> intOe)
        else $error("Interrupt pin not driven.");
endmodule
bind ufc_channel ufc_channel_asserts chk_u (.clk_sys, .rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .rxCharValid, .rxCharData, .rxStoreValid, .rxStoreData,
    .pauseSeen, .resumeSeen, .ctsN, .txStartOk, .irqOutputSelect, .intOe);

// ===== sim/ufc_remote.sv
// Remote terminal model feeding characters and the clear-to-send line.
`timescale 1ns/1ns
module ufc_remote (
    input wire clk_sys,
    input wire sendGo,
    input wire [7:0] sendByte,
    input wire ctsHold,
    output reg rxCharValid,
    output reg [7:0] rxCharData,
    output reg ctsN
);
    initial begin
        rxCharValid = 1'h0;
        rxCharData = 8'h00;
        ctsN = 1'h1;
    end
    // A character shows for one cycle, then the idle line carries no strobe.
    always @(posedge clk_sys) begin
        rxCharValid <= sendGo;
        rxCharData <= sendGo ? sendByte : ~rxCharData;
        ctsN <= ctsHold;
    end
endmodule

// ===== sim/ufc_channel_tb.sv
// Self-checking bench of the flow-control block.
`timescale 1ns/1ns
`include "ufc_consts.vh"
module ufc_channel_tb;
    reg clk_sys = 1'h0, rst = 1'h1, porRst = 1'h1;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sendByte = 8'h00;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sendGo = 1'h0;
    reg [31:0] s_axi_wdata = 32'h0, rdv;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg [5:0] rxFifoLevel = 6'h00;
    reg dsrN = 1'h0, riN = 1'h1, cdN = 1'h0, irqOutputSelect = 1'h1;
    reg ctsHold = 1'h1;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, rxCharValid, rxStoreValid, pauseSeen, resumeSeen;
    wire ctsN, txStartOk, rtsN, dtrN, intOut, intOe, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0] rxCharData, rxStoreData;
    wire [15:0] baudDivisor;
    integer nErrors = 0, checkCount = 0, cyc = 0, m;
    reg [15:0] rnd = 16'h0010;
    reg [1:0] rsp;
    reg [7:0] ch [0:3];
    reg [5:0] lv;
    ufc_channel dut_u (.clk_sys, .rst, .porRst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rxCharValid, .rxCharData, .rxFifoLevel, .rxStoreValid, .rxStoreData,
        .pauseSeen, .resumeSeen, .ctsN, .dsrN, .riN, .cdN, .txStartOk, .rtsN,
        .dtrN, .irqOutputSelect, .intOut, .intOe, .irq, .baudDivisor);
    ufc_remote remote_u (.clk_sys, .sendGo, .sendByte, .ctsHold,
        .rxCharValid, .rxCharData, .ctsN);
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            nErrors = nErrors + 1;
            endSim;
        end
    end
    function [15:0] nextRnd(input [15:0] s);
        nextRnd = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected {stored, pause, resume} for the pause-two or resume-one char.
    function [2:0] rxExp(input [1:0] md, input k);
        rxExp = k ? {~md[1], 1'h0, md[1]} : {~md[0], md[0], 1'h0};
    endfunction
    task chk(input [33:0] g, input [33:0] e);
        begin
            checkCount = checkCount + 1;
            if (g !== e) begin
                nErrors = nErrors + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task settle;
        begin
            repeat (3) @(posedge clk_sys);
            #1;
        end
    endtask
    task axiWr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            do begin
                @(posedge clk_sys);
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
            end while (!s_axi_bvalid);
            rsp = s_axi_bresp;
            s_axi_bready <= 1'h0;
        end
    endtask
    task axiRd(input [7:0] a);
        begin
            @(posedge clk_sys);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            do begin
                @(posedge clk_sys);
                if (s_axi_arready) s_axi_arvalid <= 1'h0;
            end while (!s_axi_rvalid);
            rdv = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 1'h0;
        end
    endtask
    task rdChk(input [7:0] a, input [31:0] e);
        begin
            axiRd(a);
            chk(rdv, e);
        end
    endtask
    task sendChk(input [7:0] c, input [2:0] e);
        begin
            @(posedge clk_sys);
            sendGo <= 1'h1;
            sendByte <= c;
            @(posedge clk_sys);
            sendGo <= 1'h0;
            @(posedge clk_sys);
            #1;
            chk({rxStoreValid, pauseSeen, resumeSeen}, e);
            if (e[2]) chk(rxStoreData, c);
        end
    endtask
    task endSim;
        begin
            $display("checks=%0d errors=%0d", checkCount, nErrors);
            if (nErrors == 0 && checkCount > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        porRst <= 1'h0;
        #1;
        chk({intOe, rtsN, dtrN, txStartOk, irq}, 5'h1E);
        irqOutputSelect <= 1'h0;
        for (m = 0; m < 5; m = m + 1) rdChk({m[5:0], 2'h0}, 32'h0);
        rdChk(`UFC_OFF_ISR, 32'h01);
        rdChk(`UFC_OFF_DLL, 32'h01);
        rdChk(`UFC_OFF_DLM, 32'h00);
        rdChk(`UFC_OFF_MSR, 32'hA0);
        chk(intOe, 1'h0);
        for (m = 0; m < 4; m = m + 1) begin
            rnd = nextRnd(rnd);
            ch[m] = {rnd[7:3], 1'h0, m[1:0]};
            axiWr({m[5:0] + 6'h1, 2'h0}, {24'h0, ch[m]});
            rdChk({m[5:0] + 6'h1, 2'h0}, {24'h0, ch[m]});
        end
        axiRd(8'h3C);
        chk({rsp, rdv}, {`UFC_RESP_SLVERR, 32'h0});
        axiWr(8'h3C, 32'h5A);
        chk(rsp, `UFC_RESP_SLVERR);
        axiWr(`UFC_OFF_IER, 32'h20);
        for (m = 0; m < 4; m = m + 1) begin
            axiWr(`UFC_OFF_EFR, {24'h0, 6'h08, m[1:0]});
            sendChk(ch[3], rxExp(m[1:0], 1'h0));
            axiRd(`UFC_OFF_ISR);
            chk(rdv[4], 1'h1);
            axiRd(`UFC_OFF_ISR);
            chk(rdv[4], 1'h0);
            sendChk(ch[0], rxExp(m[1:0], 1'h1));
            sendChk(ch[3] ^ 8'h05, 3'h4);
            axiRd(`UFC_OFF_ISR);
            chk(rdv[4], 1'h0);
        end
        rdChk(`UFC_OFF_IST, 32'h07);
        chk(irq, 1'h0);
        axiWr(`UFC_OFF_IEN, 32'h01);
        settle;
        chk({irq, intOut}, 2'h3);
        axiWr(`UFC_OFF_ICL, 32'h07);
        settle;
        chk({irq, intOut}, 2'h0);
        axiWr(`UFC_OFF_EFR, 32'h80);
        settle;
        chk(txStartOk, 1'h0);
        ctsHold <= 1'h0;
        settle;
        chk(txStartOk, 1'h1);
        ctsHold <= 1'h1;
        axiWr(`UFC_OFF_EFR, 32'h00);
        settle;
        chk(txStartOk, 1'h1);
        axiWr(`UFC_OFF_MCR, 32'h02);
        settle;
        chk(rtsN, 1'h0);
        axiWr(`UFC_OFF_IEN, 32'h08);
        axiWr(`UFC_OFF_EFR, 32'h40);
        for (m = 0; m < 4; m = m + 1) begin
            rnd = nextRnd(rnd);
            lv = (m == 1) ? {2'h1, rnd[3:0]} : m[0] ? 6'h03 : {m[3:0], 2'h0};
            lv = (m == 0) ? 6'h08 : lv;
            rxFifoLevel <= lv;
            settle;
            chk(rtsN, m == 1 || m == 2);
        end
        chk(irq, 1'h1);
        rdChk(`UFC_OFF_IST, 32'h08);
        rxFifoLevel <= 6'h20;
        axiWr(`UFC_OFF_EFR, 32'h00);
        settle;
        chk(rtsN, 1'h0);
        axiWr(`UFC_OFF_MCR, 32'h00);
        settle;
        chk(rtsN, 1'h1);
        rnd = nextRnd(rnd);
        axiWr(`UFC_OFF_DLL, {24'h0, rnd[7:0]});
        rst <= 1'h1;
        @(posedge clk_sys);
        rst <= 1'h0;
        settle;
        chk(baudDivisor, {8'h00, rnd[7:0]});
        rdChk(`UFC_OFF_PAU2, 32'h0);
        porRst <= 1'h1;
        @(posedge clk_sys);
        porRst <= 1'h0;
        settle;
        chk(baudDivisor, 16'h0001);
        endSim;
    end
endmodule
